// ==== design/rst_pwr_pkg.sv ====
// Purpose: shared constants and types for the reset and power-mode controller
// Assumes: 125 MHz system clock, registers on classic Wishbone, word index * 4 = byte address
// Notes: long counts are overridable by parameters of the top module
package rst_pwr_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SUPPLY_TIMEOUT_MS = 100;
  localparam int unsigned SUPPLY_TIMEOUT_CYC = (CLK_HZ / 1000) * SUPPLY_TIMEOUT_MS;
  localparam int unsigned CLK_LOSS_US = 100;
  localparam int unsigned CLK_LOSS_CYC = (CLK_HZ / 1_000_000) * CLK_LOSS_US;
  localparam int unsigned PIN_HOLD_CYC = 12;
  localparam int SUPPLY_TMR_W = 24;
  localparam int CLK_LOSS_W = 16;
  localparam int HOLD_TMR_W = 4;
  // bus geometry
  localparam int WB_ADR_W = 12;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  // register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_RESET_SOURCE = 10'h0ef;
  localparam logic [9:0] IDX_OSC_CONTROL = 10'h0b2;
  // power_control fields
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  // reset_source_reg fields
  localparam int RS_PIN = 0;
  localparam int RS_POR = 1;
  localparam int RS_CLK = 2;
  localparam int RS_WDT = 3;
  localparam int RS_SW = 4;
  localparam int RS_CMP = 5;
  localparam int RS_CNV = 6;
  localparam int NUM_SRC = 7;
  // oscillator_control fields
  localparam int OSC_CLK_LOSS_EN_BIT = 7;
  // reset values
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] OSC_CONTROL_RST = 8'h00;
  localparam logic [6:0] FLAGS_POR = 7'h02;
  localparam logic [7:0] PORT_LATCH_RST = 8'hff;
  localparam logic [2:0] WDT_INTERVAL_RST = 3'h7;
  // reset sequencer states
  typedef enum logic [1:0] {ST_POR_WAIT, ST_HOLD, ST_CLK_WAIT, ST_RUN} seq_state_type;
endpackage

// ==== design/hold_timer.sv ====
// Purpose: down-counter that stretches a reset phase after its cause goes away
// Assumes: load_i held while the cause is present
// Notes: resets to the full count so a phase that starts at power-up is already armed
`timescale 1ns/1ps
module hold_timer #(
  parameter int W = 4,
  parameter logic [W-1:0] LOAD_VAL = '1
) (
  // clock and reset
  input logic sys_clk_i,
  input logic rstn_i,
  // control
  input logic load_i,
  output logic done_o
);
  logic [W-1:0] count;

  // reload while the cause stands, then run down to zero and stay
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= LOAD_VAL;
    end else if (load_i) begin
      count <= LOAD_VAL;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done_o = (count == '0);
endmodule

// ==== design/clock_loss_detector.sv ====
// Purpose: flags a dead system oscillator after a run of cycles without it
// Assumes: counted on a free reference clock; alive_i says the oscillator toggles
// Notes: level output, held until enable drops or alive_i returns (the reset clears the enable)
`timescale 1ns/1ps
module clock_loss_detector #(
  parameter int W = 16,
  parameter logic [W-1:0] LIMIT = '1
) (
  // clock and reset
  input logic sys_clk_i,
  input logic rstn_i,
  // control and status
  input logic enable_i,
  input logic alive_i,
  output logic loss_o
);
  logic [W-1:0] dead_cnt;

  // one-shot: any sign of life restarts it, saturates at the limit
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dead_cnt <= '0;
    end else if (!enable_i || alive_i) begin
      dead_cnt <= '0;
    end else if (dead_cnt != LIMIT) begin
      dead_cnt <= dead_cnt + 1'b1;
    end
  end

  assign loss_o = enable_i && (dead_cnt == LIMIT);
endmodule

// ==== design/reset_source_power_control.sv ====
// Purpose: merges the reset sources, sequences reset entry and exit, idle and stop modes
// Assumes: all inputs synchronous to sys_clk_i; reset pin resolved outside from oe
// Notes: source flags survive the system reset; rstn_i and each new reset entry reload them
`timescale 1ns/1ps
module reset_source_power_control #(
  parameter int unsigned SUPPLY_TMO_CYCLES = rst_pwr_pkg::SUPPLY_TIMEOUT_CYC,
  parameter int unsigned CLK_LOSS_CYCLES = rst_pwr_pkg::CLK_LOSS_CYC
) (
  // clock and reset
  input logic sys_clk_i,
  input logic rstn_i,
  // wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [rst_pwr_pkg::WB_ADR_W-1:0] wb_adr_i,
  input logic [rst_pwr_pkg::WB_SEL_W-1:0] wb_sel_i,
  input logic [rst_pwr_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [rst_pwr_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // reset sources
  input logic supply_ok_i,
  input logic supply_monitor_enable_pin_i,
  input logic rst_pin_i,
  input logic convert_start_pin_i,
  input logic comparator_out_i,
  input logic wdt_timeout_i,
  input logic osc_running_i,
  // reset pin drive (open drain)
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  // core and clock status
  input logic osc_stable_i,
  input logic irq_pending_i,
  input logic wdt_disable_i,
  // reset and power outputs
  output logic sys_rst_o,
  output logic cpu_halt_o,
  output logic cpu_clk_gate_o,
  output logic osc_off_o,
  output logic osc_default_o,
  output logic pc_clear_o,
  output logic sp_reset_o,
  output logic pullup_en_o,
  output logic port_latch_load_o,
  output logic [7:0] port_latch_o,
  output logic wdt_en_o,
  output logic [2:0] wdt_interval_o
);
  import rst_pwr_pkg::*;

  seq_state_type state, next_state;
  logic [NUM_SRC-1:0] flags, req_vec;
  logic en_cmp, en_cnv, clk_loss_en, idle, stop;
  logic ack;
  logic [7:0] rd_byte;
  logic bus_wr, wr_pc, wr_rs, wr_osc;
  logic soft_por, soft_rst;
  logic supply_low, por_req, any_req, clk_loss;
  logic por_entry, new_entry;
  logic por_load, por_done, hold_load, hold_done;
  logic in_reset;

  // word address compare, shared by the write strobes and the read mux
  function automatic logic reg_hit(input logic [WB_ADR_W-1:0] adr, input logic [9:0] idx);
    return adr[WB_ADR_W-1:2] == idx;
  endfunction

  // bus: ack one cycle after the strobe, write lands on the acking edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_cyc_i && wb_stb_i && !ack;
    end
  end

  assign wb_ack_o = ack;
  // cpu is halted in reset, so bus writes then are dropped
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0] && !in_reset;
  assign wr_pc = bus_wr && reg_hit(wb_adr_i, IDX_POWER_CONTROL);
  assign wr_rs = bus_wr && reg_hit(wb_adr_i, IDX_RESET_SOURCE);
  assign wr_osc = bus_wr && reg_hit(wb_adr_i, IDX_OSC_CONTROL);

  // read mux; unmapped words and power_control read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(wb_adr_i, IDX_RESET_SOURCE)) begin
      rd_byte = {1'b0, flags};
    end else if (reg_hit(wb_adr_i, IDX_OSC_CONTROL)) begin
      rd_byte[OSC_CLK_LOSS_EN_BIT] = clk_loss_en;
    end
  end

  // read data registered with the ack
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack) begin
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // force bits are write-only pulses, never stored
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_por <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      soft_por <= wr_rs && wb_dat_i[RS_POR];
      soft_rst <= wr_rs && wb_dat_i[RS_SW];
    end
  end

  // source enables; cleared by every system reset like any other control bit
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_cmp <= 1'b0;
      en_cnv <= 1'b0;
    end else if (in_reset) begin
      en_cmp <= 1'b0;
      en_cnv <= 1'b0;
    end else if (wr_rs) begin
      en_cmp <= wb_dat_i[RS_CMP];
      en_cnv <= wb_dat_i[RS_CNV];
    end
  end

  // clock-loss detector enable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_loss_en <= OSC_CONTROL_RST[OSC_CLK_LOSS_EN_BIT];
    end else if (in_reset) begin
      clk_loss_en <= OSC_CONTROL_RST[OSC_CLK_LOSS_EN_BIT];
    end else if (wr_osc) begin
      clk_loss_en <= wb_dat_i[OSC_CLK_LOSS_EN_BIT];
    end
  end

  // idle: left by an enabled interrupt, but a fresh write wins over it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle <= POWER_CONTROL_RST[PC_IDLE_BIT];
    end else if (in_reset) begin
      idle <= 1'b0;
    end else if (wr_pc && wb_dat_i[PC_IDLE_BIT]) begin
      idle <= 1'b1;
    end else if (irq_pending_i) begin
      idle <= 1'b0;
    end
  end

  // stop: only a reset ends it; reserved bits of the write are ignored
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop <= POWER_CONTROL_RST[PC_STOP_BIT];
    end else if (in_reset) begin
      stop <= 1'b0;
    end else if (wr_pc && wb_dat_i[PC_STOP_BIT]) begin
      stop <= 1'b1;
    end
  end

  // reset requests; the pin is not its own source while we pull it
  assign supply_low = supply_monitor_enable_pin_i && !supply_ok_i;
  always_comb begin
    req_vec = '0;
    req_vec[RS_PIN] = !rst_pin_i && !rst_pin_oe_o;
    req_vec[RS_POR] = supply_low || soft_por;
    req_vec[RS_CLK] = clk_loss;
    req_vec[RS_WDT] = wdt_timeout_i;
    req_vec[RS_SW] = soft_rst;
    req_vec[RS_CMP] = en_cmp && !comparator_out_i;
    req_vec[RS_CNV] = en_cnv && !convert_start_pin_i;
  end

  assign por_req = req_vec[RS_POR];
  assign any_req = |req_vec;
  assign por_entry = por_req && (state != ST_POR_WAIT);
  assign new_entry = any_req && (state == ST_RUN || state == ST_CLK_WAIT);

  // sequencer: power-on wait, stretch, clock wait, run
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (por_req) begin
          next_state = ST_POR_WAIT;
        end else if (any_req) begin
          next_state = ST_HOLD;
        end
      end
      ST_CLK_WAIT: begin
        if (por_req) begin
          next_state = ST_POR_WAIT;
        end else if (any_req) begin
          next_state = ST_HOLD;
        end else if (osc_stable_i) begin
          next_state = ST_RUN;
        end
      end
      ST_POR_WAIT: begin
        if (por_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (por_req) begin
          next_state = ST_POR_WAIT;
        end else if (hold_done) begin
          next_state = ST_CLK_WAIT;
        end
      end
      default: begin
        next_state = ST_POR_WAIT;
      end
    endcase
  end

  // state register; power-up of this logic is itself a power-on reset
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_POR_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // source flags: power-on clears the others, an entry from run or clock wait replaces them, others accumulate in the stretch
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_flag
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        flags[g] <= FLAGS_POR[g];
      end else if (por_entry) begin
        flags[g] <= FLAGS_POR[g];
      end else if (new_entry) begin
        flags[g] <= req_vec[g];
      end else if (state == ST_HOLD && req_vec[g]) begin
        flags[g] <= 1'b1;
      end
    end
  end

  // supply timeout restarts while the supply is low
  assign por_load = (state != ST_POR_WAIT) || supply_low;
  hold_timer #(
    .W(SUPPLY_TMR_W),
    .LOAD_VAL(SUPPLY_TMR_W'(SUPPLY_TMO_CYCLES))
  ) u_supply_timer (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .load_i(por_load),
    .done_o(por_done)
  );

  // stretch counted from the last cycle any cause was present
  assign hold_load = (state != ST_HOLD) || any_req;
  hold_timer #(
    .W(HOLD_TMR_W),
    .LOAD_VAL(HOLD_TMR_W'(PIN_HOLD_CYC))
  ) u_hold_timer (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .load_i(hold_load),
    .done_o(hold_done)
  );

  // counts on the reference clock, so a stopped oscillator is still seen
  clock_loss_detector #(
    .W(CLK_LOSS_W),
    .LIMIT(CLK_LOSS_W'(CLK_LOSS_CYCLES))
  ) u_clock_loss (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .enable_i(clk_loss_en),
    .alive_i(osc_running_i),
    .loss_o(clk_loss)
  );

  // watchdog comes out of every reset enabled
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdt_en_o <= 1'b1;
    end else if (in_reset) begin
      wdt_en_o <= 1'b1;
    end else if (wdt_disable_i) begin
      wdt_en_o <= 1'b0;
    end
  end

  assign wdt_interval_o = WDT_INTERVAL_RST;

  // reset outputs decoded from the state register, except rst_pin_o, which is tied low
  assign in_reset = (state == ST_POR_WAIT) || (state == ST_HOLD);
  assign sys_rst_o = in_reset;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = (state == ST_POR_WAIT);
  assign cpu_halt_o = (state != ST_RUN);
  assign pc_clear_o = (state != ST_RUN);
  assign osc_default_o = (state != ST_RUN);
  // only the stack pointer is reset; ram gets no clear strobe at all
  assign sp_reset_o = in_reset;
  // pull-ups stay off in reset to save power
  assign pullup_en_o = !in_reset;
  assign port_latch_load_o = in_reset;
  assign port_latch_o = PORT_LATCH_RST;
  assign cpu_clk_gate_o = idle || stop;
  assign osc_off_o = stop;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_idle_gate;
    wr_pc && wb_dat_i[PC_IDLE_BIT] |=> cpu_clk_gate_o && !osc_off_o [*1];
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle write did not gate cpu");

  property p_pc_reads_zero;
    wb_ack_o && !wb_we_i && reg_hit(wb_adr_i, IDX_POWER_CONTROL) |-> wb_dat_o[7:0] == 8'h00;
  endproperty
  a_pc_reads_zero: assert property (p_pc_reads_zero) else $error("mode bits read nonzero");

  property p_stop_osc;
    wr_pc && wb_dat_i[PC_STOP_BIT] |=> osc_off_o ##1 (osc_off_o || in_reset);
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("stop write left oscillator on");

  property p_reset_outputs;
    in_reset |-> cpu_halt_o && pc_clear_o && sp_reset_o && port_latch_load_o;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs wrong");

  property p_ports_in_reset;
    in_reset |-> !pullup_en_o && port_latch_o == PORT_LATCH_RST;
  endproperty
  a_ports_in_reset: assert property (p_ports_in_reset) else $error("port state wrong");

  property p_supply_hold;
    supply_low |=> rst_pin_oe_o && sys_rst_o;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("low supply not held");

  property p_pin_release;
    $fell(rst_pin_oe_o) |-> $past(por_done) && sys_rst_o;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin freed early");

  property p_pin_only_por;
    rst_pin_oe_o |-> state == ST_POR_WAIT && flags == FLAGS_POR;
  endproperty
  a_pin_only_por: assert property (p_pin_only_por) else $error("pin driven off power-on");

  // cycles left of the stretch after a pin release; counted, since a long repeat is slow
  logic [HOLD_TMR_W-1:0] since_pin;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_pin <= '0;
    end else if ($rose(rst_pin_i) && state == ST_HOLD && !por_req) begin
      since_pin <= HOLD_TMR_W'(PIN_HOLD_CYC);
    end else if (since_pin != '0) begin
      since_pin <= since_pin - 1'b1;
    end
  end

  property p_pin_stretch;
    ($rose(rst_pin_i) && state == ST_HOLD && !por_req) || since_pin > 4'h1 |-> sys_rst_o;
  endproperty
  a_pin_stretch: assert property (p_pin_stretch) else $error("pin reset too short");

  property p_soft;
    wr_rs && wb_dat_i[RS_SW] |-> ##2 sys_rst_o && (flags[RS_SW] || flags[RS_POR]);
  endproperty
  a_soft: assert property (p_soft) else $error("soft force ignored");

  property p_cnv;
    state == ST_RUN && en_cnv && !convert_start_pin_i && !por_req |=> sys_rst_o && flags[RS_CNV];
  endproperty
  a_cnv: assert property (p_cnv) else $error("convert-start reset missed");

  property p_clk_loss;
    state == ST_RUN && clk_loss && !por_req |=> sys_rst_o && flags[RS_CLK] && !flags[RS_POR];
  endproperty
  a_clk_loss: assert property (p_clk_loss) else $error("clock loss reset missed");

  property p_wdt_exit;
    $fell(in_reset) |-> wdt_en_o && wdt_interval_o == WDT_INTERVAL_RST;
  endproperty
  a_wdt_exit: assert property (p_wdt_exit) else $error("watchdog not armed on exit");

  c_por_exit: cover property ($fell(in_reset) && flags[RS_POR]);
  c_pin_exit: cover property ($fell(in_reset) && flags[RS_PIN]);
  c_soft_exit: cover property ($fell(in_reset) && flags[RS_SW]);
  c_idle_wake: cover property (cpu_clk_gate_o ##1 !cpu_clk_gate_o && !in_reset);
endmodule

// ==== sim/reset_env_model.sv ====
// Purpose: stand-in for the reset pin, supply monitor and on-chip reset sources
// Assumes: the bench commands each condition as a level, changed just after a clock edge
// Notes: the reset pin has a pull-up, so a released pin reads high
`timescale 1ns/1ps
module reset_env_model (
  // clock
  input wire logic sys_clk_i,
  // bench commands
  input wire logic ext_low_i,
  input wire logic supply_low_i,
  input wire logic cmp_low_i,
  input wire logic cnv_low_i,
  input wire logic wdt_req_i,
  input wire logic osc_dead_i,
  // design side of the reset pin and oscillator
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic osc_off_o,
  // levels seen by the design
  output logic supply_ok_o,
  output logic rst_pin_level_o,
  output logic comparator_out_o,
  output logic convert_start_o,
  output logic wdt_timeout_o,
  output logic osc_running_o,
  output logic osc_stable_o
);
  logic stable;
  // wired pin: device or outside party may pull it low
  assign rst_pin_level_o = !((rst_pin_oe_o && !rst_pin_o) || ext_low_i);
  // source levels, all active low except the watchdog request
  assign supply_ok_o = !supply_low_i;
  assign comparator_out_o = !cmp_low_i;
  assign convert_start_o = !cnv_low_i;
  assign wdt_timeout_o = wdt_req_i;
  // stop mode really stops the oscillator
  assign osc_running_o = !osc_off_o && !osc_dead_i;
  // settles one cycle after it runs again
  always_ff @(posedge sys_clk_i) begin
    stable <= osc_running_o;
  end
  assign osc_stable_o = stable;
endmodule

// ==== sim/reset_source_power_control_bench.sv ====
// Purpose: self-checking bench for the reset and power-mode controller
// Assumes: short supply and clock-loss counts; single-cycle Wishbone master
// Notes: flags are read back only after the sequencer reaches run
`timescale 1ns/1ps
module reset_source_power_control_bench;
  import rst_pwr_pkg::*;
  localparam logic [11:0] A_PC = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [11:0] A_RS = {IDX_RESET_SOURCE, 2'b00};
  localparam logic [11:0] A_OSC = {IDX_OSC_CONTROL, 2'b00};
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, irq = 0, wdis = 0, mon_en = 1;
  logic [3:0] sel = 4'h1;
  logic ext_low = 0, sup_low = 0, cmp_low = 0, cnv_low = 0, wdt_req = 0, osc_dead = 0;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] dat_o;
  logic ack, sup_ok, pin_lvl, cmp_o, cnv_o, wdt_o, osc_run, osc_stb, pin_o, pin_oe;
  logic sys_rst, halt, gate, osc_off, latch_ld, pull_en, wdt_en, pcclr, spr, oscdef;
  logic [7:0] latch;
  logic [2:0] wdt_iv;
  logic [7:0] q;
  int n_mismatch = 0, num_checks = 0, n;
  always #4 clk = ~clk;
  reset_source_power_control #(.SUPPLY_TMO_CYCLES(50), .CLK_LOSS_CYCLES(20)) uut (
    .sys_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .supply_ok_i(sup_ok), .supply_monitor_enable_pin_i(mon_en), .rst_pin_i(pin_lvl),
    .convert_start_pin_i(cnv_o), .comparator_out_i(cmp_o), .wdt_timeout_i(wdt_o),
    .osc_running_i(osc_run), .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe),
    .osc_stable_i(osc_stb), .irq_pending_i(irq), .wdt_disable_i(wdis),
    .sys_rst_o(sys_rst), .cpu_halt_o(halt), .cpu_clk_gate_o(gate), .osc_off_o(osc_off),
    .osc_default_o(oscdef), .pc_clear_o(pcclr), .sp_reset_o(spr), .pullup_en_o(pull_en),
    .port_latch_load_o(latch_ld), .port_latch_o(latch), .wdt_en_o(wdt_en),
    .wdt_interval_o(wdt_iv));
  reset_env_model env (
    .sys_clk_i(clk), .ext_low_i(ext_low), .supply_low_i(sup_low), .cmp_low_i(cmp_low),
    .cnv_low_i(cnv_low), .wdt_req_i(wdt_req), .osc_dead_i(osc_dead), .rst_pin_o(pin_o),
    .rst_pin_oe_o(pin_oe), .osc_off_o(osc_off), .supply_ok_o(sup_ok),
    .rst_pin_level_o(pin_lvl), .comparator_out_o(cmp_o), .convert_start_o(cnv_o),
    .wdt_timeout_o(wdt_o), .osc_running_o(osc_run), .osc_stable_o(osc_stb));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_mismatch++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input logic want);
    n = 0;
    while (sys_rst !== want && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // reset entered: pins, latches and pull-ups as required
  task automatic in_reset(input logic oe_exp);
    wait_for(1'b1);
    check(pin_oe, oe_exp);
    check({latch_ld, pull_en, latch}, {2'b10, 8'hff});
    check({halt, pcclr, spr, oscdef}, 4'hf);
  endtask
  // run reached: watchdog defaults and the recorded source
  task automatic finish(input logic [7:0] flags);
    wait_for(1'b0);
    n = 0;
    while (halt !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check({halt, pull_en, wdt_en, wdt_iv}, {3'b011, 3'h7});
    check({pcclr, oscdef, spr}, 3'h0);
    xfer(A_RS, 1'b0, 8'h00);
    check(q, flags);
    $display("test done, flags %h", flags);
  endtask
  task automatic t_power_on;
    sup_low <= 1'b1;
    repeat (100) @(posedge clk);
    check({sys_rst, pin_oe}, 2'b11);
    sup_low <= 1'b0;
    finish(8'h02);
    xfer(12'h004, 1'b0, 8'h00);
    check(q, 8'h00);
  endtask
  task automatic t_idle_stop_pin;
    sel <= 4'h0;
    xfer(A_PC, 1'b1, 8'h01);
    check(gate, 1'b0);
    sel <= 4'h1;
    xfer(A_PC, 1'b1, 8'h01);
    check({gate, osc_off, wdt_en}, 3'b101);
    xfer(A_PC, 1'b0, 8'h00);
    check(q, 8'h00);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    repeat (2) @(posedge clk);
    check(gate, 1'b0);
    xfer(A_PC, 1'b1, 8'h02);
    check({gate, osc_off}, 2'b11);
    ext_low <= 1'b1;
    in_reset(1'b0);
    ext_low <= 1'b0;
    n = 0;
    while (sys_rst !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check(n >= 12, 1'b1);
    check(osc_off, 1'b0);
    finish(8'h01);
  endtask
  task automatic t_soft;
    wdis <= 1'b1;
    @(posedge clk);
    wdis <= 1'b0;
    repeat (2) @(posedge clk);
    check(wdt_en, 1'b0);
    xfer(A_RS, 1'b1, 8'h10);
    in_reset(1'b0);
    finish(8'h10);
  endtask
  // comparator assumed already running before its enable
  task automatic t_cmp;
    xfer(A_RS, 1'b1, 8'h20);
    cmp_low <= 1'b1;
    in_reset(1'b0);
    cmp_low <= 1'b0;
    finish(8'h20);
  endtask
  // pin routing assumed set up before the enable
  task automatic t_cnv;
    xfer(A_RS, 1'b1, 8'h40);
    cnv_low <= 1'b1;
    in_reset(1'b0);
    cnv_low <= 1'b0;
    finish(8'h40);
  endtask
  task automatic t_wdt;
    wdt_req <= 1'b1;
    @(posedge clk);
    wdt_req <= 1'b0;
    in_reset(1'b0);
    finish(8'h08);
  endtask
  task automatic t_clk_loss;
    xfer(A_OSC, 1'b1, 8'h80);
    osc_dead <= 1'b1;
    in_reset(1'b0);
    osc_dead <= 1'b0;
    finish(8'h04);
  endtask
  task automatic t_supply;
    xfer(A_RS, 1'b1, 8'h02);
    in_reset(1'b1);
    finish(8'h02);
    sup_low <= 1'b1;
    in_reset(1'b1);
    sup_low <= 1'b0;
    finish(8'h02);
    mon_en <= 1'b0;
    sup_low <= 1'b1;
    repeat (5) @(posedge clk);
    check(sys_rst, 1'b0);
    sup_low <= 1'b0;
    mon_en <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_power_on();
    t_idle_stop_pin();
    t_soft();
    t_cmp();
    t_cnv();
    t_wdt();
    t_clk_loss();
    t_supply();
    wrap_up();
  end
  // whole run needs several hundred cycles
  initial begin
    #(8 * 20000);
    n_mismatch++;
    wrap_up();
  end
endmodule
